// file: rtl/nvss_defines.svh
// Timing counts for the nonvolatile store and recall sequencer
`ifndef NVSS_DEFINES_SVH
`define NVSS_DEFINES_SVH
`define NVSS_CLK_NS 40
`define NVSS_CNT_W 20
`define NVSS_FA_MS 20
`define NVSS_FA_CYC ((`NVSS_FA_MS * 1000000) / `NVSS_CLK_NS)
`define NVSS_STORE_MS 8
`define NVSS_STORE_CYC ((`NVSS_STORE_MS * 1000000) / `NVSS_CLK_NS)
`define NVSS_RECALL_US 200
`define NVSS_RECALL_CYC ((`NVSS_RECALL_US * 1000) / `NVSS_CLK_NS)
`define NVSS_GRACE_NS 25
`define NVSS_GRACE_RAW (`NVSS_GRACE_NS / `NVSS_CLK_NS)
`define NVSS_GRACE_CYC ((`NVSS_GRACE_RAW < 1) ? 1 : `NVSS_GRACE_RAW)
`define NVSS_PROC_US 100
`define NVSS_PROC_CYC ((`NVSS_PROC_US * 1000) / `NVSS_CLK_NS)
`define NVSS_RESUME_US 5
`define NVSS_RESUME_CYC ((`NVSS_RESUME_US * 1000) / `NVSS_CLK_NS)
`define NVSS_PULL_NS 500
`define NVSS_PULL_CYC (`NVSS_PULL_NS / `NVSS_CLK_NS)
`endif

// file: rtl/nvss_pkg.sv
// Types for the nonvolatile store and recall sequencer
`include "nvss_defines.svh"
package nvss_pkg;
  typedef logic [`NVSS_CNT_W-1:0] nvss_cnt_t;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_GRACE  = 6'h02,
    ST_STORE  = 6'h04,
    ST_RECALL = 6'h08,
    ST_PULLUP = 6'h10,
    ST_PWRUP  = 6'h20
  } nvss_state_t;
  typedef enum logic [3:0] {
    OP_STORE  = 4'h1,
    OP_RECALL = 4'h2,
    OP_ENA    = 4'h4,
    OP_DIS    = 4'h8
  } nvss_op_t;
endpackage : nvss_pkg

// file: rtl/nvss_tmr_if.sv
// Load and done signals between the sequencer and its timer
`timescale 1ns/1ps
interface nvss_tmr_if;
  import nvss_pkg::*;
  logic load;
  nvss_cnt_t load_val;
  logic done;
  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface : nvss_tmr_if

// file: rtl/nvss_timer.sv
// Down counter that pulses done a fixed time after a load
`timescale 1ns/1ps
module nvss_timer
  import nvss_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  nvss_tmr_if.tmr t
);
  nvss_cnt_t cnt;
  nvss_cnt_t next_cnt;
  logic next_done;

  // Done is raised one cycle early so the owner's state lasts exactly the
  // loaded count; one extra cycle would push the 500 ns drive past its limit
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (t.load) begin
      next_cnt = t.load_val;
      next_done = (t.load_val == nvss_cnt_t'(1));
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == nvss_cnt_t'(2));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      t.done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      t.done <= next_done;
    end
  end
endmodule : nvss_timer

// file: rtl/nvss_top.sv
// Sequencer for transfers between the SRAM array and shadow cells
`timescale 1ns/1ps
`include "nvss_defines.svh"
module nvss_top
  import nvss_pkg::*;
#(
  parameter nvss_cnt_t FA_CYC = nvss_cnt_t'(`NVSS_FA_CYC),
  parameter nvss_cnt_t STORE_CYC = nvss_cnt_t'(`NVSS_STORE_CYC),
  parameter nvss_cnt_t RECALL_CYC = nvss_cnt_t'(`NVSS_RECALL_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Supply monitor and store line pin
  input wire logic supply_ok,
  input wire logic store_request_busy_line_in,
  output logic store_request_busy_line_out,
  output logic store_request_busy_line_oe,
  // Commands and SRAM write events from the serial logic
  input wire logic store_cmd,
  input wire logic recall_cmd,
  input wire logic pls_enable_cmd,
  input wire logic pls_disable_cmd,
  input wire logic sram_write,
  // Status
  output logic access_inhibit,
  output logic io_block,
  output logic power_loss_store_en,
  output logic sram_dirty,
  output logic nv_store_active,
  output logic nv_recall_active
);
  localparam nvss_cnt_t GRACE_CYC = nvss_cnt_t'(`NVSS_GRACE_CYC);
  localparam nvss_cnt_t PULL_CYC = nvss_cnt_t'(`NVSS_PULL_CYC);
  localparam int PULL_INT = `NVSS_PULL_CYC;
  localparam int RESUME_INT = `NVSS_RESUME_CYC;

  logic [1:0] rst_sync;
  logic rst_n;
  logic supply_m, supply_s;
  logic line_m, line_s, line_q;
  nvss_state_t st, next_st;
  nvss_op_t op, next_op;
  logic next_dirty, next_pls_en, next_inhibit, next_io_block;
  logic next_line_out, next_line_oe;
  logic hw_req;
  nvss_tmr_if tmr_bus ();

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin synchronisers; line idles high through its pull-up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_m <= 1'b0;
      supply_s <= 1'b0;
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_q <= 1'b1;
    end else begin
      supply_m <= supply_ok;
      supply_s <= supply_m;
      line_m <= store_request_busy_line_in;
      line_s <= line_m;
      line_q <= line_s;
    end
  end

  // Falling edge of the line while nobody on our side drives it
  assign hw_req = line_q && !line_s && !store_request_busy_line_oe;

  nvss_timer u_timer (
    .clk(core_clk),
    .rst_n(rst_n),
    .t(tmr_bus.tmr)
  );

  always_comb begin
    next_st = st;
    next_op = op;
    next_pls_en = power_loss_store_en;
    tmr_bus.load = 1'b0;
    tmr_bus.load_val = GRACE_CYC;
    case (st)
      ST_IDLE: begin
        if (!supply_s) begin
          if (power_loss_store_en && sram_dirty) begin
            next_st = ST_GRACE;
            next_op = OP_STORE;
            tmr_bus.load = 1'b1;
          end else begin
            next_st = ST_PWRUP;
          end
        end else if (hw_req) begin
          // Clean array: line low only inhibits, no store
          if (sram_dirty) begin
            next_st = ST_GRACE;
            next_op = OP_STORE;
            tmr_bus.load = 1'b1;
          end
        end else if (store_cmd || recall_cmd || pls_enable_cmd ||
                     pls_disable_cmd) begin
          next_st = ST_GRACE;
          tmr_bus.load = 1'b1;
          if (store_cmd) begin
            next_op = OP_STORE;
          end else if (recall_cmd) begin
            next_op = OP_RECALL;
          end else if (pls_enable_cmd) begin
            next_op = OP_ENA;
          end else begin
            next_op = OP_DIS;
          end
        end
      end
      ST_GRACE: begin
        if (tmr_bus.done) begin
          tmr_bus.load = 1'b1;
          case (op)
            OP_STORE: begin
              next_st = ST_STORE;
              tmr_bus.load_val = STORE_CYC;
            end
            OP_RECALL: begin
              next_st = ST_RECALL;
              tmr_bus.load_val = RECALL_CYC;
            end
            OP_ENA: begin
              next_st = ST_IDLE;
              next_pls_en = 1'b1;
              tmr_bus.load = 1'b0;
            end
            default: begin
              next_st = ST_IDLE;
              next_pls_en = 1'b0;
              tmr_bus.load = 1'b0;
            end
          endcase
        end
      end
      ST_STORE, ST_RECALL: begin
        if (tmr_bus.done) begin
          next_st = ST_PULLUP;
          tmr_bus.load = 1'b1;
          tmr_bus.load_val = PULL_CYC;
        end
      end
      ST_PULLUP: begin
        if (tmr_bus.done) begin
          next_st = supply_s ? ST_IDLE : ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        if (supply_s) begin
          next_st = ST_RECALL;
          next_op = OP_RECALL;
          tmr_bus.load = 1'b1;
          tmr_bus.load_val = FA_CYC;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    // A write in the cycle the array is snapshotted keeps it dirty
    next_dirty = sram_dirty;
    if (next_st == ST_STORE || next_st == ST_RECALL) begin
      next_dirty = 1'b0;
    end
    if (sram_write && !access_inhibit) begin
      next_dirty = 1'b1;
    end
    next_inhibit = (next_st == ST_STORE) || (next_st == ST_RECALL) ||
                   (next_st == ST_PWRUP) ||
                   ((next_st == ST_IDLE) && (!supply_s || !line_s)) ||
                   ((next_st == ST_PULLUP) && !supply_s);
    next_io_block = (next_st == ST_STORE) || (next_st == ST_RECALL) ||
                    (next_st == ST_PWRUP);
    next_line_oe = (next_st == ST_STORE) || (next_st == ST_RECALL) ||
                   (next_st == ST_PULLUP);
    next_line_out = (next_st == ST_PULLUP);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_PWRUP;
      op <= OP_RECALL;
      sram_dirty <= 1'b0;
      power_loss_store_en <= 1'b1;
      access_inhibit <= 1'b1;
      io_block <= 1'b1;
      store_request_busy_line_oe <= 1'b0;
      store_request_busy_line_out <= 1'b0;
      nv_store_active <= 1'b0;
      nv_recall_active <= 1'b0;
    end else begin
      st <= next_st;
      op <= next_op;
      sram_dirty <= next_dirty;
      power_loss_store_en <= next_pls_en;
      access_inhibit <= next_inhibit;
      io_block <= next_io_block;
      store_request_busy_line_oe <= next_line_oe;
      store_request_busy_line_out <= next_line_out;
      nv_store_active <= (next_st == ST_STORE);
      nv_recall_active <= (next_st == ST_RECALL);
    end
  end

  // Helper: length of a recall run
  nvss_cnt_t rec_len;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_len <= '0;
    end else begin
      rec_len <= (st == ST_RECALL) ? rec_len + 1'b1 : '0;
    end
  end

  property p_fa_bound;
    @(posedge core_clk) disable iff (!rst_n)
    rec_len <= FA_CYC;
  endproperty
  a_fa_bound: assert property (p_fa_bound)
    else $error("recall ran too long");

  property p_grace_open;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(st == ST_GRACE) && supply_s |-> !access_inhibit;
  endproperty
  a_grace_open: assert property (p_grace_open)
    else $error("access closed during grace");

  property p_nv_inhibit;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_STORE || st == ST_RECALL) |-> access_inhibit;
  endproperty
  a_nv_inhibit: assert property (p_nv_inhibit)
    else $error("access open during nv operation");

  property p_clean_skip;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_IDLE && !sram_dirty && (!supply_s || hw_req)) |=>
      st != ST_GRACE;
  endproperty
  a_clean_skip: assert property (p_clean_skip)
    else $error("store started on clean array");

  property p_cmd_start;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_IDLE && supply_s && !hw_req && store_cmd) |=>
      st == ST_GRACE ##[1:4] st == ST_STORE;
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("store command not acted on");

  property p_io_block;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_STORE || st == ST_RECALL) |-> io_block;
  endproperty
  a_io_block: assert property (p_io_block)
    else $error("serial io open during nv operation");

  property p_line_low;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_IDLE && !line_s) |=> access_inhibit == (st != ST_GRACE);
  endproperty
  a_line_low: assert property (p_line_low)
    else $error("access open while line low");

  property p_resume;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_IDLE && supply_s && $rose(line_s)) |->
      ##[1:RESUME_INT] (!access_inhibit || st != ST_IDLE);
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after line high");

  property p_pull_len;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(st == ST_PULLUP) |->
      (store_request_busy_line_oe && store_request_busy_line_out)
      ##[1:PULL_INT] !store_request_busy_line_out;
  endproperty
  a_pull_len: assert property (p_pull_len)
    else $error("high drive missing or too long");

  property p_busy_low;
    @(posedge core_clk) disable iff (!rst_n)
    (st == ST_STORE || st == ST_RECALL) |->
      store_request_busy_line_oe && !store_request_busy_line_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy not driven low");
endmodule : nvss_top

// file: tb/nvss_host_model.sv
// Host side model: pulls the store line low and resolves the wire
`timescale 1ns/1ps
module nvss_host_model (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic start,
  input wire logic [3:0] hold,
  // Device pin drive
  input wire logic dut_oe,
  input wire logic dut_out,
  // Resolved wire
  output logic line
);
  logic [3:0] left = 4'h0;
  always_ff @(posedge clk) begin
    if (start) begin
      left <= hold;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  // Open drain with pull-up: any low wins, released line reads high
  assign line = (left != 4'h0) ? 1'b0 : (dut_oe ? dut_out : 1'b1);
endmodule : nvss_host_model

// file: tb/tb.sv
// Self-checking bench for the store and recall sequencer
`timescale 1ns/1ps
module tb;
  import nvss_pkg::*;
  localparam int FA = 40;
  localparam int ST = 30;
  localparam int RC = 20;
  localparam int P_WR = 0;
  localparam int P_ST = 1;
  localparam int P_RC = 2;
  localparam int P_EN = 3;
  localparam int P_DIS = 4;
  localparam int P_HOST = 5;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_ok = 1'b1;
  logic start = 1'b0;
  logic [3:0] hold = 4'h3;
  logic st_c = 1'b0, rc_c = 1'b0, en_c = 1'b0, dis_c = 1'b0, wr = 1'b0;
  logic line, oe, out, inh, iob, pls_en, dirty, st_a, rc_a;
  int num_errors = 0;
  int n_compared = 0;
  always #20 core_clk = ~core_clk;
  nvss_top #(
    .FA_CYC(nvss_cnt_t'(FA)),
    .STORE_CYC(nvss_cnt_t'(ST)),
    .RECALL_CYC(nvss_cnt_t'(RC))
  ) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .supply_ok(supply_ok),
    .store_request_busy_line_in(line),
    .store_request_busy_line_out(out),
    .store_request_busy_line_oe(oe),
    .store_cmd(st_c), .recall_cmd(rc_c), .pls_enable_cmd(en_c),
    .pls_disable_cmd(dis_c), .sram_write(wr), .access_inhibit(inh),
    .io_block(iob), .power_loss_store_en(pls_en), .sram_dirty(dirty),
    .nv_store_active(st_a), .nv_recall_active(rc_a)
  );
  nvss_host_model i_host (
    .clk(core_clk), .start(start), .hold(hold),
    .dut_oe(oe), .dut_out(out), .line(line)
  );
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Drive the strobe picked by k; no ref arguments, for older simulators
  task automatic drive(input int k, input logic v);
    case (k)
      P_WR: wr = v;
      P_ST: st_c = v;
      P_RC: rc_c = v;
      P_EN: en_c = v;
      P_DIS: dis_c = v;
      default: start = v;
    endcase
  endtask : drive
  task automatic pulse(input int k);
    drive(k, 1'b1);
    cyc(1);
    drive(k, 1'b0);
  endtask : pulse
  // Bounded wait until the line is released and access is open again
  task automatic wait_idle(input int lim, output int n);
    n = 0;
    while ((inh !== 1'b0 || oe !== 1'b0 || iob !== 1'b0) && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_idle
  // Command was just taken; follow it to the end of the pull-up phase
  task automatic run_op(input logic st, input int len);
    int n;
    chk("grace_open", 0, inh);
    n = 0;
    while ((st ? st_a : rc_a) !== 1'b1 && n < 6) begin
      cyc(1);
      n++;
    end
    chk("busy_drive", 4'b1110, {inh, iob, oe, out});
    chk("op_kind", {st, !st}, {st_a, rc_a});
    wr = 1'b1;
    n = 0;
    while ((st ? st_a : rc_a) === 1'b1 && n < 100) begin
      cyc(1);
      wr = 1'b0;
      n++;
    end
    chk("op_len", len, n);
    n = 0;
    while (oe === 1'b1 && n < 30) begin
      cyc(1);
      n++;
    end
    chk("pullup_len", 1, n > 0 && n <= 12);
    chk("released", 2'b00, {oe, iob});
    if (st) begin
      chk("write_ignored", 0, dirty);
    end
  endtask : run_op
  task automatic t_pwrup;
    int n;
    chk("pwrup_inhibit", 2'b11, {inh, iob});
    wait_idle(FA + 40, n);
    chk("pwrup_time", 1, n <= FA + 25);
    chk("pwrup_flags", 2'b10, {pls_en, dirty});
    $display("test pwrup done");
  endtask : t_pwrup
  task automatic t_cmds;
    pulse(P_WR);
    chk("dirty_set", 1, dirty);
    pulse(P_ST);
    run_op(1'b1, ST);
    pulse(P_RC);
    run_op(1'b0, RC);
    $display("test store recall done");
  endtask : t_cmds
  task automatic t_mode;
    int n;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        pulse(P_DIS);
      end else begin
        pulse(P_EN);
      end
      chk("mode_grace", 0, inh);
      // The mode flips when the grace cycle ends, after the strobe drops
      n = 0;
      while (pls_en !== i[0] && n < 8) begin
        cyc(1);
        n++;
      end
      wait_idle(60, n);
      chk("mode_set", i, pls_en);
    end
    $display("test mode done");
  endtask : t_mode
  // Slow host holds the line longer; clean data must not be stored
  task automatic t_hw(input logic [3:0] h, input logic w);
    int n;
    if (w) begin
      pulse(P_WR);
    end
    hold = h;
    pulse(P_HOST);
    cyc(4);
    chk("hw_inhibit", 1, inh);
    n = 0;
    while (st_a !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk("hw_store", w, st_a);
    wait_idle(ST + 120, n);
    chk("hw_resume", 1, n < 125);
    chk("hw_clean", 0, dirty);
    $display("test hardware store done");
  endtask : t_hw
  task automatic t_loss;
    int n;
    pulse(P_WR);
    supply_ok = 1'b0;
    n = 0;
    while (st_a !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("loss_store", 2'b11, {st_a, inh});
    n = 0;
    while (oe !== 1'b0 && n < ST + 40) begin
      cyc(1);
      n++;
    end
    chk("low_inhibit", 1, inh);
    supply_ok = 1'b1;
    wait_idle(FA + 40, n);
    chk("recall_time", 1, n <= FA + 25);
    $display("test power loss done");
  endtask : t_loss
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
  initial begin
    cyc(3);
    arst_n = 1'b1;
    t_pwrup();
    t_cmds();
    t_mode();
    t_hw(4'h4, 1'b1);
    t_hw(4'h8, 1'b0);
    t_loss();
    summarize();
  end
endmodule : tb
